// file: hdl/prw_top.sv
// Chosen here: the register addresses and strobed register access.
`include "prw_params.svh"
`timescale 1ns/1ps
`default_nettype none

module prw_top #(
  parameter int unsigned DEGLITCH_CYC = `PRW_DEGLITCH_MS * 1000 * `PRW_CLK_MHZ,
  parameter int unsigned PERIOD_CYC = `PRW_PERIOD_MS * 1000 * `PRW_CLK_MHZ,
  parameter int unsigned RST_PULSE_CYC = `PRW_RST_PULSE_US * `PRW_CLK_MHZ,
  parameter int unsigned PULSE_MAX_CYC = `PRW_PULSE_MAX_US * `PRW_CLK_MHZ,
  parameter int unsigned STOP_MIN_CYC = `PRW_STOP_MIN_US * `PRW_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic input_valid_in,
  input wire logic thermal_warn_in,
  input wire logic pulse_cmd_in,
  input wire logic reset_request_in,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reset_out_n,
  output logic reset_waiting_out,
  output logic switch1_throw_a_en,
  output logic switch1_throw_b_en,
  output logic switch2_throw_a_en,
  output logic switch2_throw_b_en,
  output logic battery_sense_tap_en,
  output logic [1:0] eoc_mode,
  output logic [1:0] discharge_ocp_sel,
  output logic [2:0] float_offset_sel,
  output logic auto_recharge_en,
  output logic half_current_en,
  output logic watchdog_en
);

  prw_pkg::prw_state_t s_q;
  prw_pkg::prw_state_t s_d;

  // Shared decode for link commands and bus-written commands
  function automatic prw_pkg::prw_state_t prw_apply(input prw_pkg::prw_state_t s, input logic [5:0] code);
    prw_pkg::prw_state_t r;
    r = s;
    case (code)
      6'h01: r.sw1a = 1'b0;
      6'h02: r.sw1a = 1'b1;
      6'h03: r.sw1b = 1'b0;
      6'h04: r.sw1b = 1'b1;
      6'h05: r.sw2a = 1'b0;
      6'h06: r.sw2a = 1'b1;
      6'h07: r.sw2b = 1'b0;
      6'h08: r.sw2b = 1'b1;
      6'h09: r.tap = 1'b0;
      6'h0a: r.tap = 1'b1;
      6'h0b: r.eoc = `PRW_EOC_OFF;
      6'h0c: r.eoc = `PRW_EOC_5PCT;
      6'h0d: r.eoc = `PRW_EOC_2P5PCT;
      6'h0e: r.ocp = `PRW_OCP_900MA;
      6'h0f: r.ocp = `PRW_OCP_450MA;
      6'h10: r.ocp = `PRW_OCP_250MA;
      6'h11: r.ocp = `PRW_OCP_100MA;
      6'h12: r.flt = `PRW_FLOAT_NONE;
      6'h13: r.flt = 3'h1;
      6'h14: r.flt = 3'h2;
      6'h15: r.flt = 3'h3;
      6'h16: r.flt = 3'h4;
      6'h18: r.arc = 1'b0;
      6'h19: r.arc = 1'b1;
      6'h1a: r.wd_en = 1'b0;
      6'h1b: r.wd_en = 1'b1;
      6'h1c: r.half = 1'b0;
      6'h1d: r.half = 1'b1;
      default: r.wd_en = s.wd_en;
    endcase
    case (code)
      6'h01,
      6'h02,
      6'h03,
      6'h04,
      6'h05,
      6'h06,
      6'h07,
      6'h08,
      6'h09,
      6'h0a,
      6'h0b,
      6'h0c,
      6'h0d,
      6'h0e,
      6'h0f,
      6'h10,
      6'h11,
      6'h12,
      6'h13,
      6'h14,
      6'h15,
      6'h16,
      6'h18,
      6'h19,
      6'h1a,
      6'h1b,
      6'h1c,
      6'h1d: begin
        r.last_cmd = code[4:0];
      end
      default: r.last_cmd = s.last_cmd;
    endcase
    return r;
  endfunction

  logic fall;
  logic rise;
  logic stop_hit;
  logic have_cmd;
  logic [5:0] cmd_code;
  logic wd_off_evt;

  always_comb begin
    s_d = s_q;
    // Only the second and third flops feed the edge logic, so the first one may go metastable safely
    s_d.sync1 = pulse_cmd_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    fall = s_q.prev & ~s_q.sync2;
    rise = ~s_q.prev & s_q.sync2;
    stop_hit = 1'b0;

    if (s_q.sync2) begin
      s_d.lo_cnt = 16'h0000;
      if (rise) begin
        s_d.hi_cnt = 16'h0001;
      end else if (s_q.hi_cnt != 16'hffff) begin
        s_d.hi_cnt = s_q.hi_cnt + 16'h0001;
      end
    end else begin
      if (s_q.lo_cnt != 16'hffff) begin
        s_d.lo_cnt = s_q.lo_cnt + 16'h0001;
      end
      // Long low closes the frame exactly once
      if (s_q.framed && s_q.lo_cnt == 16'(STOP_MIN_CYC - 1)) begin
        stop_hit = 1'b1;
      end
    end

    if (fall) begin
      // Anything longer than a legal pulse counts as a start bit
      if (s_q.hi_cnt > 16'(PULSE_MAX_CYC)) begin
        s_d.framed = 1'b1;
        s_d.pcount = 6'h00;
      end else if (s_q.framed && s_q.pcount != 6'h3f) begin
        s_d.pcount = s_q.pcount + 6'h01;
      end
    end

    have_cmd = 1'b0;
    cmd_code = 6'h00;
    if (stop_hit) begin
      s_d.framed = 1'b0;
      have_cmd = 1'b1;
      cmd_code = s_q.pcount;
    end else if (reg_wr && reg_addr == `PRW_REG_CMD) begin
      have_cmd = 1'b1;
      cmd_code = {1'b0, reg_wdata[4:0]};
    end
    if (have_cmd) begin
      s_d = prw_apply(s_d, cmd_code);
    end
    wd_off_evt = s_q.wd_en & ~s_d.wd_en;

    s_d.half_eff = s_q.half | thermal_warn_in;

    // Reset sequencer drives only its two pins; settings above are never touched here
    s_d.tmr = s_q.tmr + 32'h0000_0001;
    case (s_q.rst_state)
      prw_pkg::PRW_IDLE: begin
        s_d.tmr = 32'h0000_0000;
        if (s_q.wd_en) begin
          s_d.rst_state = prw_pkg::PRW_PEND;
        end else if (input_valid_in) begin
          s_d.rst_state = prw_pkg::PRW_DEGL;
        end
      end
      prw_pkg::PRW_DEGL: begin
        if (!input_valid_in) begin
          s_d.rst_state = prw_pkg::PRW_IDLE;
        end else if (s_q.tmr == 32'(DEGLITCH_CYC - 1)) begin
          s_d.rst_state = prw_pkg::PRW_PEND;
          s_d.tmr = 32'h0000_0000;
        end
      end
      prw_pkg::PRW_PEND: begin
        if (s_q.wd_en) begin
          // Clear seen anywhere in the period; a clear in the expiry cycle counts for this period and the next
          if (s_q.tmr == 32'(PERIOD_CYC - 1)) begin
            s_d.tmr = 32'h0000_0000;
            s_d.wd_clr = reset_request_in;
            if (!s_q.wd_clr && !reset_request_in) begin
              s_d.rst_state = prw_pkg::PRW_PULSE;
            end
          end else if (reset_request_in) begin
            s_d.wd_clr = 1'b1;
          end
        end else if (!input_valid_in) begin
          s_d.rst_state = prw_pkg::PRW_IDLE;
        end else if (reset_request_in || s_q.tmr == 32'(PERIOD_CYC - 1)) begin
          s_d.rst_state = prw_pkg::PRW_PULSE;
          s_d.tmr = 32'h0000_0000;
        end
      end
      prw_pkg::PRW_PULSE: begin
        if (s_q.tmr == 32'(RST_PULSE_CYC - 1)) begin
          s_d.tmr = 32'h0000_0000;
          s_d.wd_clr = 1'b0;
          s_d.rst_state = s_q.wd_en ? prw_pkg::PRW_PEND : prw_pkg::PRW_DONE;
        end
      end
      prw_pkg::PRW_DONE: begin
        s_d.tmr = 32'h0000_0000;
        if (s_q.wd_en) begin
          s_d.rst_state = prw_pkg::PRW_PEND;
        end else if (!input_valid_in) begin
          s_d.rst_state = prw_pkg::PRW_IDLE;
        end
      end
      default: begin
        s_d.rst_state = prw_pkg::PRW_IDLE;
        s_d.tmr = 32'h0000_0000;
      end
    endcase
    if (wd_off_evt) begin
      s_d.rst_state = prw_pkg::PRW_IDLE;
      s_d.tmr = 32'h0000_0000;
      s_d.wd_clr = 1'b0;
    end

    s_d.rst_out_n = (s_d.rst_state != prw_pkg::PRW_PULSE);
    s_d.waiting = (s_d.rst_state == prw_pkg::PRW_PEND);

    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `PRW_REG_CMD: s_d.rdata = {3'h0, s_q.last_cmd};
        `PRW_REG_CFG0: s_d.rdata = {s_q.wd_en, s_q.half, s_q.arc, s_q.tap, s_q.sw2b, s_q.sw2a, s_q.sw1b, s_q.sw1a};
        `PRW_REG_CFG1: s_d.rdata = {1'b0, s_q.flt, s_q.ocp, s_q.eoc};
        `PRW_REG_STATUS: s_d.rdata = {s_q.framed, s_q.wd_clr, 1'b0, s_q.rst_state};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.sw1a <= 1'b1;
      s_q.sw2a <= 1'b1;
      s_q.sw1b <= 1'b0;
      s_q.sw2b <= 1'b0;
      s_q.eoc <= `PRW_EOC_5PCT;
      s_q.ocp <= `PRW_OCP_900MA;
      s_q.flt <= `PRW_FLOAT_NONE;
      s_q.rst_state <= prw_pkg::PRW_IDLE;
      s_q.rst_out_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign reset_out_n = s_q.rst_out_n;
  assign reset_waiting_out = s_q.waiting;
  assign switch1_throw_a_en = s_q.sw1a;
  assign switch1_throw_b_en = s_q.sw1b;
  assign switch2_throw_a_en = s_q.sw2a;
  assign switch2_throw_b_en = s_q.sw2b;
  assign battery_sense_tap_en = s_q.tap;
  assign eoc_mode = s_q.eoc;
  assign discharge_ocp_sel = s_q.ocp;
  assign float_offset_sel = s_q.flt;
  assign auto_recharge_en = s_q.arc;
  assign half_current_en = s_q.half_eff;
  assign watchdog_en = s_q.wd_en;

endmodule // prw_top

`default_nettype wire

// file: hdl/prw_params.svh
`ifndef PRW_PARAMS_SVH
`define PRW_PARAMS_SVH

// Core clock rate
`define PRW_CLK_MHZ 40

// Reset and watchdog timing
`define PRW_DEGLITCH_MS 150
`define PRW_PERIOD_MS 4000
`define PRW_RST_PULSE_US 1000

// Pulse-count link timing
`define PRW_PULSE_MIN_US 100
`define PRW_PULSE_MAX_US 120
`define PRW_START_MIN_US 350
`define PRW_START_MAX_US 400
`define PRW_STOP_MIN_US 500

// Register bus offsets
`define PRW_REG_CMD 4'h0
`define PRW_REG_CFG0 4'h1
`define PRW_REG_CFG1 4'h2
`define PRW_REG_STATUS 4'h3

// Setting encodings and reset values
`define PRW_EOC_5PCT 2'h0
`define PRW_EOC_2P5PCT 2'h1
`define PRW_EOC_OFF 2'h2
`define PRW_OCP_900MA 2'h0
`define PRW_OCP_450MA 2'h1
`define PRW_OCP_250MA 2'h2
`define PRW_OCP_100MA 2'h3
`define PRW_FLOAT_NONE 3'h0

`endif

// file: hdl/prw_pkg.sv
package prw_pkg;

  typedef enum logic [4:0] {
    PRW_IDLE = 5'h01,
    PRW_DEGL = 5'h02,
    PRW_PEND = 5'h04,
    PRW_PULSE = 5'h08,
    PRW_DONE = 5'h10
  } prw_rst_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    logic framed;
    logic [5:0] pcount;
    logic [4:0] last_cmd;
    logic sw1a;
    logic sw1b;
    logic sw2a;
    logic sw2b;
    logic tap;
    logic [1:0] eoc;
    logic [1:0] ocp;
    logic [2:0] flt;
    logic arc;
    logic half;
    logic half_eff;
    logic wd_en;
    prw_rst_state_t rst_state;
    logic [31:0] tmr;
    logic wd_clr;
    logic rst_out_n;
    logic waiting;
    logic [7:0] rdata;
  } prw_state_t;

endpackage

// file: sim/prw_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module prw_top_chk #(
  parameter int unsigned DEGLITCH_CYC = 50,
  parameter int unsigned PERIOD_CYC = 200,
  parameter int unsigned RST_PULSE_CYC = 10,
  parameter int unsigned STOP_MIN_CYC = 40
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic input_valid_in,
  input wire logic thermal_warn_in,
  input wire logic pulse_cmd_in,
  input wire logic reg_wr,
  input wire logic reset_out_n,
  input wire logic reset_waiting_out,
  input wire logic battery_sense_tap_en,
  input wire logic [1:0] eoc_mode,
  input wire logic [1:0] discharge_ocp_sel,
  input wire logic [2:0] float_offset_sel,
  input wire logic auto_recharge_en,
  input wire logic half_current_en,
  input wire logic watchdog_en
);
  logic [31:0] low_q, valid_q, pend_q, idle_q;
  logic [9:0] cfg;
  // Half current left out: thermal warning moves it freely
  assign cfg = {battery_sense_tap_en, eoc_mode, discharge_ocp_sel, float_offset_sel, auto_recharge_en, watchdog_en};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q <= 32'h0;
      valid_q <= 32'h0;
      pend_q <= 32'h0;
      idle_q <= 32'h0;
    end else begin
      low_q <= reset_out_n ? 32'h0 : low_q + 32'h1;
      valid_q <= input_valid_in ? valid_q + 32'h1 : 32'h0;
      pend_q <= reset_waiting_out ? pend_q + 32'h1 : 32'h0;
      idle_q <= pulse_cmd_in ? 32'h0 : idle_q + 32'h1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_idle_invalid: assert property (!watchdog_en && !$past(watchdog_en) && !$past(input_valid_in) |-> !reset_waiting_out)
    else $error("waiting raised without valid input");
  a_deglitch_min: assert property ($rose(reset_waiting_out) && !watchdog_en |-> valid_q >= DEGLITCH_CYC)
    else $error("waiting raised before deglitch time");
  a_period_max: assert property ($fell(reset_out_n) && !watchdog_en |-> pend_q <= PERIOD_CYC + 2)
    else $error("smart reset came late");
  a_pulse_width: assert property ($rose(reset_out_n) && $stable(watchdog_en) |-> low_q == RST_PULSE_CYC)
    else $error("reset pulse width wrong");
  a_one_shot: assert property ($fell(reset_out_n) && !watchdog_en |-> $past(reset_waiting_out))
    else $error("smart reset without pending state");
  a_no_side: assert property ($fell(reset_out_n) |=> $stable(cfg))
    else $error("reset changed a setting");
  a_wd_disable: assert property ($fell(watchdog_en) |-> ##[0:2] !reset_waiting_out)
    else $error("disable did not restore smart reset");
  a_thermal_half: assert property (thermal_warn_in |=> half_current_en)
    else $error("thermal warning did not force half current");
  a_cfg_after_stop: assert property ($changed(cfg) && !$past(reg_wr) && !$past(reg_wr, 2) |-> idle_q >= STOP_MIN_CYC)
    else $error("setting changed before stop interval");
endmodule // prw_top_chk
`default_nettype wire

// file: sim/prw_proc_model.sv
`timescale 1ns/1ps
`default_nettype none
module prw_proc_model #(
  parameter int START_CYC = 20,
  parameter int PULSE_CYC = 8,
  parameter int STOP_CYC = 45
) (
  input wire logic core_clk,
  output logic pulse_cmd_in
);
  initial pulse_cmd_in = 1'b0;
  task automatic hold(input logic lvl, input int cyc);
    pulse_cmd_in <= lvl;
    repeat (cyc) @(posedge core_clk);
  endtask
  task automatic send_cmd(input int n);
    @(posedge core_clk);
    hold(1'b1, START_CYC);
    hold(1'b0, PULSE_CYC);
    for (int i = 0; i < n; i++) begin
      hold(1'b1, PULSE_CYC);
      hold(1'b0, PULSE_CYC);
    end
    hold(1'b0, STOP_CYC);
  endtask
endmodule // prw_proc_model
`default_nettype wire

// file: sim/prw_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module prw_top_tb;
  localparam int DEG = 50;
  localparam int PER = 200;
  logic core_clk, rst_n, input_valid_in, thermal_warn_in, reset_request_in, reg_wr, reg_rd, pulse_cmd_in;
  logic reset_out_n, reset_waiting_out;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, e0, e1, d;
  wire logic [7:0] p0, p1;
  int error_cnt = 0, compares = 0, cyc = 0;
  prw_top #(.DEGLITCH_CYC(DEG), .PERIOD_CYC(PER), .RST_PULSE_CYC(10), .PULSE_MAX_CYC(12), .STOP_MIN_CYC(40)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .input_valid_in(input_valid_in), .thermal_warn_in(thermal_warn_in),
    .pulse_cmd_in(pulse_cmd_in), .reset_request_in(reset_request_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_out_n(reset_out_n), .reset_waiting_out(reset_waiting_out),
    .switch1_throw_a_en(p0[0]), .switch1_throw_b_en(p0[1]), .switch2_throw_a_en(p0[2]),
    .switch2_throw_b_en(p0[3]), .battery_sense_tap_en(p0[4]), .auto_recharge_en(p0[5]),
    .half_current_en(p0[6]), .watchdog_en(p0[7]), .eoc_mode(p1[1:0]), .discharge_ocp_sel(p1[3:2]),
    .float_offset_sel(p1[6:4]));
  prw_proc_model proc (.core_clk(core_clk), .pulse_cmd_in(pulse_cmd_in));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Expected settings: e0 mirrors the CFG0 layout, e1 the CFG1 layout
  task automatic upd(input int n);
    if (n >= 1 && n <= 10) e0[(n - 1) / 2] = ~n[0];
    else if (n == 11) e1[1:0] = 2'h2;
    else if (n <= 13) e1[1:0] = 2'(n - 12);
    else if (n <= 17) e1[3:2] = 2'(n - 14);
    else if (n <= 22) e1[6:4] = 3'(n - 18);
    else if (n > 23 && n < 30) e0[(n < 26) ? 5 : (n < 28) ? 7 : 6] = n[0];
  endtask
  task automatic cfg_chk();
    rd(4'h1);
    check("cfg0", d, e0);
    rd(4'h2);
    check("cfg1", d, e1);
    check("pins0", p0, e0);
    check("pins1", {1'b0, p1[6:0]}, e1);
  endtask
  task automatic watch(input int b);
    logic hit;
    hit = 1'b0;
    repeat (b) begin
      @(posedge core_clk);
      #1 if (reset_out_n !== 1'b1) hit = 1'b1;
    end
    check("reset_out_n quiet", {7'h0, hit}, 8'h0);
  endtask
  task automatic wait_low(input int b);
    int i;
    i = 0;
    while (reset_out_n !== 1'b0 && i < b) begin
      @(posedge core_clk);
      #1 i++;
    end
    check("reset_out_n", {7'h0, reset_out_n}, 8'h0);
  endtask
  initial begin
    {rst_n, input_valid_in, thermal_warn_in, reset_request_in, reg_wr, reg_rd} = 6'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h0;
    e0 = 8'h05;
    e1 = 8'h00;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    cfg_chk();
    rd(4'h8);
    check("unmapped", d, 8'h00);
    check("waiting", {7'h0, reset_waiting_out}, 8'h0);
    $display("test defaults done");
    @(posedge core_clk);
    input_valid_in <= 1'b1;
    repeat (DEG - 2) @(posedge core_clk);
    #1 check("waiting early", {7'h0, reset_waiting_out}, 8'h0);
    repeat (6) @(posedge core_clk);
    #1 check("waiting", {7'h0, reset_waiting_out}, 8'h1);
    watch(PER - 12);
    wait_low(20);
    repeat (15) @(posedge core_clk);
    watch(300);
    @(posedge core_clk);
    input_valid_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    input_valid_in <= 1'b1;
    repeat (DEG + 10) @(posedge core_clk);
    reset_request_in <= 1'b1;
    wait_low(6);
    @(posedge core_clk);
    reset_request_in <= 1'b0;
    $display("test smart reset done");
    for (int n = 1; n < 30; n++) begin
      if (n == 26 || n == 27) continue;
      proc.send_cmd(n);
      upd(n);
      repeat (4) @(posedge core_clk);
      cfg_chk();
    end
    wr(4'h0, 8'h0f);
    upd(15);
    cfg_chk();
    rd(4'h0);
    check("cmd", d, 8'h0f);
    wr(4'h0, 8'h1c);
    upd(28);
    @(posedge core_clk);
    thermal_warn_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 check("half", p0[6:6], 8'h1);
    @(posedge core_clk);
    thermal_warn_in <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 check("half", p0[6:6], 8'h0);
    $display("test settings done");
    @(posedge core_clk);
    input_valid_in <= 1'b0;
    proc.send_cmd(27);
    upd(27);
    reset_request_in <= 1'b1;
    repeat (20) @(posedge core_clk);
    reset_request_in <= 1'b0;
    watch(PER);
    wait_low(PER);
    repeat (15) @(posedge core_clk);
    cfg_chk();
    proc.send_cmd(26);
    upd(26);
    repeat (4) @(posedge core_clk);
    cfg_chk();
    check("waiting", {7'h0, reset_waiting_out}, 8'h0);
    $display("test watchdog done");
    close_out();
  end
endmodule // prw_top_tb
bind prw_top prw_top_chk #(.DEGLITCH_CYC(DEGLITCH_CYC), .PERIOD_CYC(PERIOD_CYC), .RST_PULSE_CYC(RST_PULSE_CYC),
  .STOP_MIN_CYC(STOP_MIN_CYC)) chk (.*);
`default_nettype wire
